// ===== design/usb_otg_cfg_pkg.sv
// Types shared by the USB OTG status/configuration bank
// Assumes nothing beyond a SystemVerilog compiler
package usb_otg_cfg_pkg;
   typedef logic [7:0]  byte_field_t;
   typedef logic [31:0] word_t;
   // Eye-pattern generator states
   typedef enum logic [1:0] {
      EYE_J = 2'b01,
      EYE_K = 2'b10
   } eye_state_t;
endpackage

// ===== design/usb_otg_cfg_regs.sv
// USB OTG event, error and configuration register bank
// Assumes synchronous register port on CORE_CLK; pins arrive asynchronously
`timescale 1ns/1ps
`default_nettype none
`include "usb_otg_cfg_regs.svh"

module usb_otg_cfg_regs
   import usb_otg_cfg_pkg::*;
#(
   parameter int ONE_MS_CYC = `ONE_MS_CYCLES,
   parameter int BIT_CYC    = 2
) (
   // Clock and reset
   input  wire logic        CORE_CLK,
   input  wire logic        RESET_N,
   // Register port
   input  wire logic [7:0]  ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output var  logic [31:0] RDATA,
   // Asynchronous pins and comparators
   input  wire logic        ID_PIN,
   input  wire logic [1:0]  LINE_STATE,
   input  wire logic        VBUS_SESS_END,
   input  wire logic        VBUS_SESS_VALID,
   // Protocol engine events, same clock
   input  wire logic        HOST_MODE,
   input  wire logic        TOKEN_CRC_BAD,
   input  wire logic        SOF_ZERO,
   input  wire logic        XFER_BUSY,
   input  wire logic        PID_BAD,
   input  wire logic        BUS_GRANT_LATE,
   input  wire logic        RX_TRUNCATED,
   input  wire logic        EOP_DONE,
   input  wire logic        RESPONSE_SEEN,
   input  wire logic        ENGINE_DRIVING,
   // Chip power state
   input  wire logic        CHIP_IDLE,
   input  wire logic        CHIP_SLEEP,
   // Outputs
   output var  logic        EYE_DP,
   output var  logic        OE_MONITOR,
   output var  logic        MODULE_RUN,
   output var  logic        SUSPEND,
   output var  logic        CLK48_GATE,
   output var  logic        IRQ
);

   //****************************************************************
   // Input synchronisers
   //****************************************************************
   localparam int NSYNC = 5;
   logic [NSYNC-1:0] s1_q, s2_q, s3_q, pin_q;
   logic [NSYNC-1:0] pins;
   assign pins = {ID_PIN, LINE_STATE, VBUS_SESS_END, VBUS_SESS_VALID};

   // Three stages; a change counts once stages two and three agree
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         s1_q  <= '0;
         s2_q  <= '0;
         s3_q  <= '0;
         pin_q <= '0;
      end else begin
         s1_q <= pins;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (int i = 0; i < NSYNC; i++) begin
            if (s2_q[i] == s3_q[i]) begin
               pin_q[i] <= s3_q[i];
            end
         end
      end
   end

   localparam int SETTLE = `SYNC_SETTLE;
   logic [NSYNC-1:0]  pin_prev_q;
   logic [SETTLE-1:0] fill_q;
   logic              pins_armed;
   // Edges count only once filter and history hold real pin levels;
   // arming earlier turns the ID pin's step from reset to idle into an event
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         pin_prev_q <= '0;
         fill_q     <= '0;
      end else begin
         pin_prev_q <= pin_q;
         fill_q     <= {fill_q[SETTLE-2:0], 1'b1};
      end
   end
   assign pins_armed = fill_q[SETTLE-1];

   logic [NSYNC-1:0] pin_chg;
   assign pin_chg = pins_armed ? (pin_q ^ pin_prev_q) : '0;

   //****************************************************************
   // Millisecond timer and line-state watch
   //****************************************************************
   function automatic logic [19:0] cnt_next(input logic [19:0] c, input int lim);
      cnt_next = (c >= 20'(lim - 1)) ? 20'h00000 : c + 20'h00001;
   endfunction

   logic [19:0] ms_cnt_q;
   logic        ms_tick;
   assign ms_tick = (ms_cnt_q == 20'(ONE_MS_CYC - 1));
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) ms_cnt_q <= 20'h00000;
      else          ms_cnt_q <= cnt_next(ms_cnt_q, ONE_MS_CYC);
   end

   logic [19:0] ls_cnt_q;
   logic [1:0]  ls_stable_q;
   logic        ls_event;
   logic        ls_same;
   assign ls_same  = (pin_q[3:2] == pin_prev_q[3:2]);
   assign ls_event = ls_same && (ls_cnt_q == 20'(ONE_MS_CYC - 1)) && (pin_q[3:2] != ls_stable_q);
   // Restart on any line change; record a new stable state at 1 ms
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ls_cnt_q    <= 20'h00000;
         ls_stable_q <= 2'b00;
      end else if (!ls_same) begin
         ls_cnt_q <= 20'h00000;
      end else if (ls_cnt_q != 20'(ONE_MS_CYC - 1)) begin
         ls_cnt_q <= ls_cnt_q + 20'h00001;
      end else begin
         ls_stable_q <= pin_q[3:2];
      end
   end

   //****************************************************************
   // Turnaround timer
   //****************************************************************
   logic [7:0] ta_cnt_q;
   logic       ta_run_q;
   logic       ta_timeout;
   localparam int TA_LIMIT = `TURNAROUND_BITS * BIT_CYC;
   assign ta_timeout = ta_run_q && (ta_cnt_q == 8'(TA_LIMIT));
   // Counts idle after an end of packet until a response arrives
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ta_cnt_q <= 8'h00;
         ta_run_q <= 1'b0;
      end else if (EOP_DONE) begin
         ta_cnt_q <= 8'h00;
         ta_run_q <= 1'b1;
      end else if (RESPONSE_SEEN || ta_timeout) begin
         ta_run_q <= 1'b0;
      end else if (ta_run_q) begin
         ta_cnt_q <= ta_cnt_q + 8'h01;
      end
   end

   //****************************************************************
   // Register port decode
   //****************************************************************
   logic wr_event, wr_err, wr_cfg, wr_pwr, wr_iclr, wr_ien;
   assign wr_event = WR && (ADDR == `OFS_OTG_EVENT);
   assign wr_err   = WR && (ADDR == `OFS_ERR_FLAGS);
   assign wr_cfg   = WR && (ADDR == `OFS_CONFIG_ONE);
   assign wr_pwr   = WR && (ADDR == `OFS_POWER_CTL);
   assign wr_iclr  = WR && (ADDR == `OFS_IRQ_CLEAR);
   assign wr_ien   = WR && (ADDR == `OFS_IRQ_ENABLE);

   //****************************************************************
   // Event flags
   //****************************************************************
   byte_field_t event_q, event_set;
   logic        awake_q;
   always_comb begin
      event_set = 8'h00;
      event_set[`BIT_ID_CHG]      = pin_chg[4];
      event_set[`BIT_ONE_MS]      = ms_tick;
      event_set[`BIT_LINE_STABLE] = ls_event;
      event_set[`BIT_ACTIVITY]    = (|pin_chg) && !awake_q;
      event_set[`BIT_SESS_VALID]  = pin_chg[1] && pin_q[1];
      event_set[`BIT_SESS_END]    = pin_chg[1];
      event_set[`BIT_VBUS_VALID]  = pin_chg[0];
   end

   // Set beats clear so an event on the clearing cycle is kept
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) event_q <= 8'h00;
      else event_q <= ((event_q & ~(wr_event ? WDATA[7:0] : 8'h00)) | event_set) & `EVENT_MASK;
   end

   //****************************************************************
   // Error flags
   //****************************************************************
   byte_field_t err_q, err_set;
   always_comb begin
      err_set = 8'h00;
      err_set[`BIT_CRC_EOF] = HOST_MODE ? (SOF_ZERO && XFER_BUSY)
                                        : TOKEN_CRC_BAD;
      err_set[`BIT_PID]     = PID_BAD;
      err_set[`BIT_BUF]     = BUS_GRANT_LATE || RX_TRUNCATED;
      err_set[`BIT_BTO]     = ta_timeout;
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) err_q <= 8'h00;
      else err_q <= ((err_q & ~(wr_err ? WDATA[7:0] : 8'h00)) | err_set) & `ERROR_MASK;
   end

   //****************************************************************
   // Configuration and power control
   //****************************************************************
   byte_field_t cfg_q;
   logic        man_susp_q;
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) cfg_q <= `CONFIG_RESET;
      else if (wr_cfg) cfg_q <= WDATA[7:0] & `CONFIG_MASK;
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) man_susp_q <= 1'b0;
      else if (wr_pwr) man_susp_q <= WDATA[`BIT_MAN_SUSP];
   end

   //****************************************************************
   // Interrupt status, clear and enable
   //****************************************************************
   logic [1:0] ist_q, ien_q, ist_set;
   assign ist_set = {|err_set, |event_set};
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ist_q <= 2'b00;
         ien_q <= 2'b00;
      end else begin
         ist_q <= (ist_q & ~(wr_iclr ? WDATA[1:0] : 2'b00)) | ist_set;
         if (wr_ien) ien_q <= WDATA[1:0];
      end
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) IRQ <= 1'b0;
      else          IRQ <= |(ist_d() & ien_q);
   end

   function automatic logic [1:0] ist_d();
      ist_d = (ist_q & ~(wr_iclr ? WDATA[1:0] : 2'b00)) | ist_set;
   endfunction

   //****************************************************************
   // Read data, one cycle after the strobe
   //****************************************************************
   word_t rdata_d;
   always_comb begin
      rdata_d = 32'h00000000;
      unique case (ADDR)
         `OFS_OTG_EVENT:  rdata_d[7:0] = event_q;
         `OFS_ERR_FLAGS:  rdata_d[7:0] = err_q;
         `OFS_CONFIG_ONE: rdata_d[7:0] = cfg_q;
         `OFS_POWER_CTL:  rdata_d[`BIT_MAN_SUSP] = man_susp_q;
         `OFS_IRQ_STATUS: rdata_d[1:0] = ist_q;
         `OFS_IRQ_ENABLE: rdata_d[1:0] = ien_q;
         default:         rdata_d = 32'h00000000; // Unmapped and write-only read zero
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) RDATA <= 32'h00000000;
      else          RDATA <= RD ? rdata_d : 32'h00000000;
   end

   //****************************************************************
   // Power behaviour: idle stop, suspend, clock gate
   //****************************************************************
   logic suspend_d, run_d;
   assign suspend_d = man_susp_q || (cfg_q[`BIT_AUTO_SUSP] && CHIP_SLEEP);
   assign run_d     = !suspend_d && !(cfg_q[`BIT_STOP_IDLE] && CHIP_IDLE);

   // Wake detection is armed only while suspended
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         SUSPEND    <= 1'b0;
         CLK48_GATE <= 1'b0;
         MODULE_RUN <= 1'b1;
         awake_q    <= 1'b1;
      end else begin
         SUSPEND    <= suspend_d;
         CLK48_GATE <= suspend_d;
         MODULE_RUN <= run_d;
         awake_q    <= !suspend_d;
      end
   end

   //****************************************************************
   // Eye-pattern test and OE monitor
   //****************************************************************
   eye_state_t eye_q;
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) eye_q <= EYE_J;
      else if (cfg_q[`BIT_EYE_TEST] && run_d) begin
         unique case (eye_q)
            EYE_J: eye_q <= EYE_K;
            EYE_K: eye_q <= EYE_J;
            default: eye_q <= EYE_J;
         endcase
      end else eye_q <= EYE_J;
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         EYE_DP     <= 1'b0;
         OE_MONITOR <= 1'b0;
      end else begin
         EYE_DP     <= cfg_q[`BIT_EYE_TEST] && (eye_q == EYE_K);
         OE_MONITOR <= cfg_q[`BIT_OE_MON] && (ENGINE_DRIVING || cfg_q[`BIT_EYE_TEST]);
      end
   end

   //****************************************************************
   // Checks
   //****************************************************************
   a_event_w1c: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      (wr_event && WDATA[`BIT_ONE_MS] && !ms_tick) |=> !event_q[`BIT_ONE_MS])
      else $error("Timer flag not cleared by write one");
   a_zero_keeps: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      (event_q[`BIT_ID_CHG] && !(wr_event && WDATA[`BIT_ID_CHG])) |=> event_q[`BIT_ID_CHG])
      else $error("ID flag lost without a clear");
   a_id_sets: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      pin_chg[4] |=> event_q[`BIT_ID_CHG])
      else $error("ID change not flagged");
   a_timer_sets: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      ms_tick |=> event_q[`BIT_ONE_MS] ##1 (ms_cnt_q == 20'h00001))
      else $error("Timer flag or restart wrong");
   a_unimpl_zero: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      $past(RD) |-> (RDATA[31:8] == 24'h000000))
      else $error("Upper bits not zero");
   a_crc_dev: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      (!HOST_MODE && TOKEN_CRC_BAD) |=> err_q[`BIT_CRC_EOF])
      else $error("CRC5 error not flagged");
   a_eof_host: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      (HOST_MODE && SOF_ZERO && XFER_BUSY) |=> err_q[`BIT_CRC_EOF])
      else $error("EOF error not flagged");
   a_pid_sets: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      PID_BAD |=> err_q[`BIT_PID])
      else $error("PID failure not flagged");
   a_ta_timeout: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      (EOP_DONE ##1 (!EOP_DONE && !RESPONSE_SEEN) [*8]) |-> ta_run_q)
      else $error("Turnaround stopped early");
   a_auto_susp: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      (cfg_q[`BIT_AUTO_SUSP] && CHIP_SLEEP) |=> (SUSPEND && CLK48_GATE))
      else $error("Automatic suspend missing");
   a_idle_stop: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      (cfg_q[`BIT_STOP_IDLE] && CHIP_IDLE) |=> !MODULE_RUN)
      else $error("Module ran in idle");

endmodule

`default_nettype wire

// ===== design/usb_otg_cfg_regs.svh
// Register offsets, field positions, reset values and timing counts
// Assumes a 32-bit byte-addressed register port; included by the bank module
`ifndef USB_OTG_CFG_REGS_SVH
`define USB_OTG_CFG_REGS_SVH

// Register byte offsets
`define OFS_OTG_EVENT   8'h00
`define OFS_ERR_FLAGS   8'h04
`define OFS_CONFIG_ONE  8'h08
`define OFS_POWER_CTL   8'h0C
`define OFS_IRQ_STATUS  8'h10
`define OFS_IRQ_CLEAR   8'h14
`define OFS_IRQ_ENABLE  8'h18

// Event register fields
`define BIT_ID_CHG      7
`define BIT_ONE_MS      6
`define BIT_LINE_STABLE 5
`define BIT_ACTIVITY    4
`define BIT_SESS_VALID  3
`define BIT_SESS_END    2
`define BIT_VBUS_VALID  0
`define EVENT_MASK      8'hFD

// Error register fields
`define BIT_BTO         4
`define BIT_BUF         3
`define BIT_CRC_EOF     1
`define BIT_PID         0
`define ERROR_MASK      8'h1B

// Configuration fields and reset value
`define BIT_EYE_TEST    7
`define BIT_OE_MON      6
`define BIT_STOP_IDLE   4
`define BIT_AUTO_SUSP   0
`define CONFIG_MASK     8'hD1
`define CONFIG_RESET    8'h01
`define BIT_MAN_SUSP    1

// Interrupt status layout
`define IRQ_OTG         0
`define IRQ_ERR         1

// Timing
`define ONE_MS_NS       1000000
`define CLK_PERIOD_NS   40
`define ONE_MS_CYCLES   (`ONE_MS_NS / `CLK_PERIOD_NS)
`define TURNAROUND_BITS 16
`define SYNC_SETTLE     5

`endif

// ===== tb/usb_far_end.sv
// Far-end model: cable ID pin, D+/D- line state and VBUS comparators
// Assumes the bench calls its tasks by hierarchical name from one process
`timescale 1ns/1ps
`default_nettype none

module usb_far_end (
   // Clock that times every pin change
   input  wire logic       clk,
   // Pins seen by the bank
   output var  logic       id_pin,
   output var  logic [1:0] line_state,
   output var  logic       sess_end,
   output var  logic       sess_valid
);
   // ************************************************
   // Idle cable: ID high, bus at J, no VBUS
   // ************************************************
   initial begin
      id_pin = 1'b1;
      line_state = 2'b01;
      sess_end = 1'b0;
      sess_valid = 1'b0;
   end

   // Changes land just after an edge so the bank's synchroniser sees clean levels
   task automatic flip_id();
      @(posedge clk);
      id_pin <= ~id_pin;
   endtask

   task automatic set_line(input logic [1:0] v);
      @(posedge clk);
      line_state <= v;
   endtask

   task automatic set_end(input logic v);
      @(posedge clk);
      sess_end <= v;
   endtask

   task automatic set_valid(input logic v);
      @(posedge clk);
      sess_valid <= v;
   endtask
endmodule

`default_nettype wire

// ===== tb/usb_otg_cfg_regs_bench.sv
// Self-checking bench for the OTG event, error and configuration bank
// Assumes the package, the header and the far-end model compile first
`timescale 1ns/1ps
`default_nettype none
`include "usb_otg_cfg_regs.svh"

module usb_otg_cfg_regs_bench
   import usb_otg_cfg_pkg::*;
();
   // Short timer so a millisecond fits the run
   localparam int MS = 20;
   localparam int BC = 2;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] addr = 8'h00;
   word_t wdata = '0;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   word_t rdata;
   wire logic id_pin;
   wire logic [1:0] line_state;
   wire logic sess_end;
   wire logic sess_valid;
   logic host_mode = 1'b0;
   logic xfer_busy = 1'b0;
   logic driving = 1'b0;
   logic chip_idle = 1'b0;
   logic chip_sleep = 1'b0;
   logic [6:0] ev = '0; // Engine pulses, one bit each
   logic eye_dp, oe_mon, run, suspend, gate48, irq;
   int n_fail = 0;
   int checks = 0;

   always #20 clk = ~clk;

   usb_far_end far (.clk(clk), .id_pin(id_pin), .line_state(line_state), .sess_end(sess_end),
                    .sess_valid(sess_valid));

   usb_otg_cfg_regs #(.ONE_MS_CYC(MS), .BIT_CYC(BC)) dut (
      .CORE_CLK(clk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
      .RDATA(rdata), .ID_PIN(id_pin), .LINE_STATE(line_state), .VBUS_SESS_END(sess_end),
      .VBUS_SESS_VALID(sess_valid), .HOST_MODE(host_mode), .TOKEN_CRC_BAD(ev[0]), .SOF_ZERO(ev[1]),
      .XFER_BUSY(xfer_busy), .PID_BAD(ev[2]), .BUS_GRANT_LATE(ev[3]), .RX_TRUNCATED(ev[4]),
      .EOP_DONE(ev[5]), .RESPONSE_SEEN(ev[6]), .ENGINE_DRIVING(driving), .CHIP_IDLE(chip_idle),
      .CHIP_SLEEP(chip_sleep), .EYE_DP(eye_dp), .OE_MONITOR(oe_mon), .MODULE_RUN(run),
      .SUSPEND(suspend), .CLK48_GATE(gate48), .IRQ(irq));

   // ************************************************
   // Access and checking tasks
   // ************************************************
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic fail(input string msg);
      n_fail++;
      $display("[ERR] %0t %s", $time, msg);
   endtask

   task automatic wr(input logic [7:0] a, input word_t d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output word_t d);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic chk_rd(input logic [7:0] a, input word_t exp, input word_t m);
      word_t d;
      rd(a, d);
      checks++;
      if ((d & m) !== (exp & m)) fail($sformatf("read %h got %h want %h", a, d, exp));
   endtask

   task automatic chk_sig(input logic got, input logic exp, input string what);
      checks++;
      if (got !== exp) fail($sformatf("%s is %b", what, got));
   endtask

   // Bounded wait for flags; running out ends the run
   task automatic poll(input logic [7:0] a, input word_t m, input int lim);
      word_t d;
      int i;
      for (i = 0; i < lim; i++) begin
         rd(a, d);
         if ((d & m) === m) break;
      end
      checks++;
      if (i == lim) begin
         fail($sformatf("flags %h never set at %h", m, a));
         wrap_up();
      end
   endtask

   task automatic pulse(input int i);
      @(posedge clk);
      ev[i] <= 1'b1;
      @(posedge clk);
      ev[i] <= 1'b0;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Hang guard well above the longest sequence
   initial begin
      #(40 * 20000);
      fail("run too long");
      wrap_up();
   end

   // ************************************************
   // Test sequence
   // ************************************************
   initial begin
      logic e0;
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      cyc(8);
      chk_rd(`OFS_OTG_EVENT, 32'h0, 32'hFFFF_FF9F);
      chk_rd(`OFS_ERR_FLAGS, 32'h0, '1);
      chk_rd(`OFS_CONFIG_ONE, 32'h1, '1);
      wr(`OFS_CONFIG_ONE, 32'hFFFF_FFFF);
      chk_rd(`OFS_CONFIG_ONE, 32'hD1, '1);
      wr(8'h1C, 32'hFFFF_FFFF);
      chk_rd(8'h1C, 32'h0, '1);
      wr(`OFS_CONFIG_ONE, 32'h0);
      $display("test reset done");
      far.flip_id();
      poll(`OFS_OTG_EVENT, 32'h80, 20);
      wr(`OFS_OTG_EVENT, 32'hFFFF_FF7F);
      chk_rd(`OFS_OTG_EVENT, 32'h80, 32'h80);
      wr(`OFS_OTG_EVENT, 32'h80);
      chk_rd(`OFS_OTG_EVENT, 32'h0, 32'h80);
      wr(`OFS_OTG_EVENT, 32'h0D);
      far.set_end(1'b1);
      poll(`OFS_OTG_EVENT, 32'h0C, 20);
      wr(`OFS_OTG_EVENT, 32'h0D);
      far.set_end(1'b0);
      poll(`OFS_OTG_EVENT, 32'h04, 20);
      chk_rd(`OFS_OTG_EVENT, 32'h0, 32'h08);
      far.set_valid(1'b1);
      poll(`OFS_OTG_EVENT, 32'h01, 20);
      wr(`OFS_OTG_EVENT, 32'h40);
      poll(`OFS_OTG_EVENT, 32'h40, 20);
      wr(`OFS_OTG_EVENT, 32'h20);
      far.set_line(2'b10);
      chk_rd(`OFS_OTG_EVENT, 32'h0, 32'h20);
      poll(`OFS_OTG_EVENT, 32'h20, 30);
      $display("test events done");
      pulse(0);
      chk_rd(`OFS_ERR_FLAGS, 32'h02, '1);
      wr(`OFS_ERR_FLAGS, 32'h02);
      @(posedge clk);
      host_mode <= 1'b1;
      xfer_busy <= 1'b1;
      pulse(0);
      chk_rd(`OFS_ERR_FLAGS, 32'h0, '1);
      pulse(1);
      chk_rd(`OFS_ERR_FLAGS, 32'h02, '1);
      wr(`OFS_ERR_FLAGS, 32'h02);
      @(posedge clk);
      xfer_busy <= 1'b0;
      pulse(1);
      chk_rd(`OFS_ERR_FLAGS, 32'h0, '1);
      pulse(2);
      chk_rd(`OFS_ERR_FLAGS, 32'h01, '1);
      pulse(3);
      chk_rd(`OFS_ERR_FLAGS, 32'h09, '1);
      wr(`OFS_ERR_FLAGS, 32'h08);
      pulse(4);
      chk_rd(`OFS_ERR_FLAGS, 32'h09, '1);
      wr(`OFS_ERR_FLAGS, 32'h1F);
      pulse(5);
      pulse(6);
      cyc(40);
      chk_rd(`OFS_ERR_FLAGS, 32'h0, '1);
      pulse(5);
      cyc(26);
      chk_rd(`OFS_ERR_FLAGS, 32'h0, 32'h10);
      cyc(10);
      chk_rd(`OFS_ERR_FLAGS, 32'h10, 32'h10);
      $display("test errors done");
      wr(`OFS_CONFIG_ONE, 32'h80);
      cyc(2);
      e0 = eye_dp;
      cyc(1);
      chk_sig(eye_dp, ~e0, "eye output");
      wr(`OFS_CONFIG_ONE, 32'h0);
      cyc(3);
      chk_sig(eye_dp, 1'b0, "eye output");
      wr(`OFS_CONFIG_ONE, 32'h40);
      cyc(3);
      chk_sig(oe_mon, 1'b0, "oe monitor");
      @(posedge clk);
      driving <= 1'b1;
      cyc(3);
      chk_sig(oe_mon, 1'b1, "oe monitor");
      wr(`OFS_CONFIG_ONE, 32'h0);
      cyc(3);
      chk_sig(oe_mon, 1'b0, "oe monitor");
      @(posedge clk);
      driving <= 1'b0;
      chip_idle <= 1'b1;
      cyc(3);
      chk_sig(run, 1'b1, "run");
      wr(`OFS_CONFIG_ONE, 32'h10);
      cyc(3);
      chk_sig(run, 1'b0, "run");
      @(posedge clk);
      chip_idle <= 1'b0;
      cyc(3);
      chk_sig(run, 1'b1, "run");
      @(posedge clk);
      chip_sleep <= 1'b1;
      wr(`OFS_CONFIG_ONE, 32'h0);
      cyc(3);
      chk_sig(suspend, 1'b0, "suspend");
      wr(`OFS_CONFIG_ONE, 32'h1);
      cyc(3);
      chk_sig(suspend, 1'b1, "suspend");
      chk_sig(gate48, 1'b1, "clock gate");
      wr(`OFS_CONFIG_ONE, 32'h0);
      cyc(3);
      chk_sig(suspend, 1'b0, "suspend");
      wr(`OFS_POWER_CTL, 32'h2);
      cyc(3);
      chk_sig(gate48, 1'b1, "clock gate");
      chk_rd(`OFS_POWER_CTL, 32'h2, '1);
      wr(`OFS_OTG_EVENT, 32'h10);
      far.set_line(2'b01);
      poll(`OFS_OTG_EVENT, 32'h10, 20);
      wr(`OFS_POWER_CTL, 32'h0);
      chip_sleep <= 1'b0;
      $display("test config done");
      // Only the error line is enabled, the running timer would mask the check
      wr(`OFS_ERR_FLAGS, 32'h1F);
      wr(`OFS_IRQ_CLEAR, 32'h3);
      wr(`OFS_IRQ_ENABLE, 32'h2);
      chk_rd(`OFS_IRQ_ENABLE, 32'h2, 32'h2);
      pulse(2);
      cyc(2);
      chk_sig(irq, 1'b1, "irq");
      chk_rd(`OFS_IRQ_STATUS, 32'h2, 32'h2);
      wr(`OFS_IRQ_ENABLE, 32'h0);
      cyc(2);
      chk_sig(irq, 1'b0, "irq");
      wr(`OFS_IRQ_ENABLE, 32'h2);
      cyc(2);
      chk_sig(irq, 1'b1, "irq");
      wr(`OFS_ERR_FLAGS, 32'h1F);
      wr(`OFS_IRQ_CLEAR, 32'h3);
      cyc(2);
      chk_sig(irq, 1'b0, "irq");
      $display("test interrupt done");
      wrap_up();
   end
endmodule

`default_nettype wire
